// ==== pkg/fsi_pkg.sv ====
// Constants and types for the forwarding status and interrupt aggregator
package fsi_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [31:0] FSI_IDX_FORWARDING_STATUS   = 32'h0000_0022;
  localparam logic [31:0] FSI_IDX_INT_CTL   = 32'h0000_0023;
  localparam logic [31:0] FSI_IDX_INT_STS   = 32'h0000_0024;

  localparam logic [31:0] FSI_ADDR_FORWARDING_STATUS  = {FSI_IDX_FORWARDING_STATUS[29:0], 2'b00};
  localparam logic [31:0] FSI_ADDR_INT_CTL  = {FSI_IDX_INT_CTL[29:0], 2'b00};
  localparam logic [31:0] FSI_ADDR_INT_STS  = {FSI_IDX_INT_STS[29:0], 2'b00};
  localparam logic [31:0] FSI_ADDR_EVT_STS  = 32'h0000_0094;
  localparam logic [31:0] FSI_ADDR_EVT_EN   = 32'h0000_0098;
  localparam logic [31:0] FSI_ADDR_EVT_CLR  = 32'h0000_009C;

  localparam int FSI_BIT_LOCKED   = 0;
  localparam int FSI_BIT_FAIL     = 2;
  localparam int FSI_BIT_RX0      = 0;
  localparam int FSI_BIT_RX1      = 1;
  localparam int FSI_BIT_TX       = 4;
  localparam int FSI_BIT_GLOBAL   = 7;
  localparam int FSI_BIT_EV_FAIL  = 0;
  localparam int FSI_BIT_EV_LOST  = 1;
  localparam int FSI_BIT_EV_IRQ   = 2;

  localparam logic [7:0] FSI_CTL_MASK   = 8'h93;
  localparam logic [7:0] FSI_RST_CTL    = 8'h00;
  localparam logic [2:0] FSI_RST_EVT    = 3'h0;
  localparam logic [1:0] FSI_MODE_OFF   = 2'h0;

  localparam int FSI_NUM_RX = 2;
  localparam int FSI_NUM_EV = 3;

  typedef enum logic [1:0] {FSI_SYNC_IDLE, FSI_SYNC_WAIT, FSI_SYNC_RUN} fsi_sync_t;

endpackage

// ==== rtl/fsi_sync_monitor.sv ====
// Tracks synchronized forwarding health and the sticky sync-fail flag
`timescale 1ns/1ps
module fsi_sync_monitor
  import fsi_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Forwarding engine
  input  wire logic [1:0] sync_forward_mode_sel,
  input  wire logic       fwd_frame_done,
  input  wire logic       fwd_sync_ok,
  // Register side
  input  wire logic       fail_read_clr,
  output logic            sync_forward_locked,
  output logic            sync_forward_fail_flag,
  output logic            fail_event
);

  fsi_sync_t state;
  fsi_sync_t next_state;
  logic      enabled;
  logic      fail_now;

  assign enabled = sync_forward_mode_sel != FSI_MODE_OFF;

  always_comb
  begin
    next_state = state;
    unique case (state)
      FSI_SYNC_IDLE: if (enabled) next_state = FSI_SYNC_WAIT;
      FSI_SYNC_WAIT: if (fwd_frame_done && fwd_sync_ok) next_state = FSI_SYNC_RUN;
      FSI_SYNC_RUN:  if (!fwd_sync_ok) next_state = FSI_SYNC_WAIT;
    endcase
    if (!enabled)
      next_state = FSI_SYNC_IDLE;
  end

  // Failure only counts after one synchronized frame got out
  assign fail_now = enabled && state == FSI_SYNC_RUN && !fwd_sync_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= FSI_SYNC_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_forward_locked <= 1'b0;
    else
      sync_forward_locked <= enabled && fwd_sync_ok;
  end

  // Set wins over the read clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_forward_fail_flag <= 1'b0;
    else if (fail_now)
      sync_forward_fail_flag <= 1'b1;
    else if (fail_read_clr)
      sync_forward_fail_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fail_event <= 1'b0;
    else
      fail_event <= fail_now;
  end

  a_locked_off_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !enabled |=> !sync_forward_locked) else $error("locked while disabled");

  a_fail_needs_run: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sync_forward_fail_flag) |-> $past(state) == FSI_SYNC_RUN)
    else $error("fail flag without a prior good frame");

endmodule

// ==== rtl/fsi_source_pending.sv ====
// Pending bit for one interrupt source, cleared by its status reads
`timescale 1ns/1ps
module fsi_source_pending
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Source
  input  wire logic src_event,
  input  wire logic src_status_read,
  // Result
  output logic      src_pending
);

  // Event beats the clearing read in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_pending <= 1'b0;
    else if (src_event)
      src_pending <= 1'b1;
    else if (src_status_read)
      src_pending <= 1'b0;
  end

endmodule

// ==== rtl/fsi_irq_aggregator.sv ====
// Forwarding status and interrupt aggregation with APB register access
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module fsi_irq_aggregator
  import fsi_pkg::*;
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Forwarding engine
  input  wire logic [1:0]            sync_forward_mode_sel,
  input  wire logic                  fwd_frame_done,
  input  wire logic                  fwd_sync_ok,
  // Source events and clearing status reads
  input  wire logic [FSI_NUM_RX-1:0] rx_port_event,
  input  wire logic [FSI_NUM_RX-1:0] rx_port_status_read,
  input  wire logic                  tx_port_event,
  input  wire logic                  tx_port_event_status_reg_read,
  // Controller interrupt lines
  output logic                       irq_to_controller,
  output logic                       evt_irq
);
  import fsi_pkg::*;

  logic [7:0]            interrupt_control;
  logic [FSI_NUM_RX-1:0] rx_pending;
  logic                  csi_tx_source_pending;
  logic                  global_irq_pending;
  logic                  sync_forward_locked;
  logic                  sync_forward_fail_flag;
  logic                  fail_event;
  logic                  lost_event;
  logic                  locked_q;
  logic [FSI_NUM_EV-1:0] evt_status;
  logic [FSI_NUM_EV-1:0] evt_enable;
  logic [FSI_NUM_EV-1:0] evt_set;
  logic [FSI_NUM_EV-1:0] evt_clr;
  logic                  access;
  logic                  wr_access;
  logic                  rd_access;
  logic                  addr_ok;
  logic [7:0]            fwd_status_view;
  logic [7:0]            int_status_view;
  logic [31:0]           next_prdata;
  logic                  irq_prev;

  function automatic logic known_addr(input logic [31:0] a);
    known_addr = a == FSI_ADDR_FORWARDING_STATUS || a == FSI_ADDR_INT_CTL || a == FSI_ADDR_INT_STS
              || a == FSI_ADDR_EVT_STS || a == FSI_ADDR_EVT_EN || a == FSI_ADDR_EVT_CLR;
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
    hit = a == reg_addr;
  endfunction

  // Zero wait state slave: access phase completes in one cycle
  assign access    = psel && penable;
  assign wr_access = access && pwrite;
  assign rd_access = access && !pwrite;
  assign addr_ok   = known_addr(paddr);

  fsi_sync_monitor u_sync
  (
    .pclk                   (pclk),
    .presetn                (presetn),
    .sync_forward_mode_sel  (sync_forward_mode_sel),
    .fwd_frame_done         (fwd_frame_done),
    .fwd_sync_ok            (fwd_sync_ok),
    .fail_read_clr          (rd_access && hit(paddr, FSI_ADDR_FORWARDING_STATUS)),
    .sync_forward_locked    (sync_forward_locked),
    .sync_forward_fail_flag (sync_forward_fail_flag),
    .fail_event             (fail_event)
  );

  genvar gi;
  generate
    for (gi = 0; gi < FSI_NUM_RX; gi++)
    begin : g_rx
      fsi_source_pending u_rx
      (
        .pclk            (pclk),
        .presetn         (presetn),
        .src_event       (rx_port_event[gi]),
        .src_status_read (rx_port_status_read[gi]),
        .src_pending     (rx_pending[gi])
      );
    end
  endgenerate

  fsi_source_pending u_tx
  (
    .pclk            (pclk),
    .presetn         (presetn),
    .src_event       (tx_port_event),
    .src_status_read (tx_port_event_status_reg_read),
    .src_pending     (csi_tx_source_pending)
  );

  // Control register, only documented bits are writable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_control <= FSI_RST_CTL;
    else if (wr_access && hit(paddr, FSI_ADDR_INT_CTL) && pstrb[0])
      interrupt_control <= pwdata[7:0] & FSI_CTL_MASK;
  end

  // Global pending ignores the global enable
  assign global_irq_pending =
      (csi_tx_source_pending && interrupt_control[FSI_BIT_TX])
    | (rx_pending[1] && interrupt_control[FSI_BIT_RX1])
    | (rx_pending[0] && interrupt_control[FSI_BIT_RX0]);

  always_comb
  begin
    fwd_status_view = 8'h00;
    fwd_status_view[FSI_BIT_LOCKED] = sync_forward_locked;
    fwd_status_view[FSI_BIT_FAIL]   = sync_forward_fail_flag;
    int_status_view = 8'h00;
    int_status_view[FSI_BIT_GLOBAL] = global_irq_pending;
    int_status_view[FSI_BIT_TX]     = csi_tx_source_pending;
    int_status_view[FSI_BIT_RX1]    = rx_pending[1];
    int_status_view[FSI_BIT_RX0]    = rx_pending[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_to_controller <= 1'b0;
    else
      irq_to_controller <= interrupt_control[FSI_BIT_GLOBAL] && global_irq_pending;
  end

  // Own event status: sync failure, lock lost, controller irq rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      locked_q <= 1'b0;
    else
      locked_q <= sync_forward_locked;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_prev <= 1'b0;
    else
      irq_prev <= irq_to_controller;
  end

  assign lost_event = locked_q && !sync_forward_locked;

  always_comb
  begin
    evt_set = '0;
    evt_set[FSI_BIT_EV_FAIL] = fail_event;
    evt_set[FSI_BIT_EV_LOST] = lost_event;
    evt_set[FSI_BIT_EV_IRQ]  = irq_to_controller && !irq_prev;
    evt_clr = '0;
    if (wr_access && hit(paddr, FSI_ADDR_EVT_CLR) && pstrb[0])
      evt_clr = pwdata[FSI_NUM_EV-1:0];
  end

  // Set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_status <= FSI_RST_EVT;
    else
      evt_status <= (evt_status & ~evt_clr) | evt_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_enable <= FSI_RST_EVT;
    else if (wr_access && hit(paddr, FSI_ADDR_EVT_EN) && pstrb[0])
      evt_enable <= pwdata[FSI_NUM_EV-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_irq <= 1'b0;
    else
      evt_irq <= |(evt_status & evt_enable);
  end

  // Read data mux
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit(paddr, FSI_ADDR_FORWARDING_STATUS))
      next_prdata[7:0] = fwd_status_view;
    else if (hit(paddr, FSI_ADDR_INT_CTL))
      next_prdata[7:0] = interrupt_control;
    else if (hit(paddr, FSI_ADDR_INT_STS))
      next_prdata[7:0] = int_status_view;
    else if (hit(paddr, FSI_ADDR_EVT_STS))
      next_prdata[FSI_NUM_EV-1:0] = evt_status;
    else if (hit(paddr, FSI_ADDR_EVT_EN))
      next_prdata[FSI_NUM_EV-1:0] = evt_enable;
  end

  // Registered answer: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && !addr_ok;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= next_prdata;
  end

  a_irq_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    irq_to_controller |-> $past(interrupt_control[FSI_BIT_GLOBAL]))
    else $error("irq without global enable");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    interrupt_control[FSI_BIT_GLOBAL] && global_irq_pending |=> irq_to_controller)
    else $error("irq missing");

  a_global_pending: assert property (@(posedge pclk) disable iff (!presetn)
    rx_pending[0] && interrupt_control[FSI_BIT_RX0] |-> global_irq_pending)
    else $error("global pending missing");

  a_tx_event_sets: assert property (@(posedge pclk) disable iff (!presetn)
    tx_port_event |=> csi_tx_source_pending) else $error("tx pending not set");

  a_rx_hold_pending: assert property (@(posedge pclk) disable iff (!presetn)
    rx_pending[1] && !rx_port_status_read[1] |=> rx_pending[1])
    else $error("rx pending cleared without read");

  a_ctl_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && hit(paddr, FSI_ADDR_INT_CTL) && pstrb[0]
      |=> interrupt_control[FSI_BIT_TX] == $past(pwdata[FSI_BIT_TX]))
    else $error("enable write lost");

  a_fail_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_access && hit(paddr, FSI_ADDR_FORWARDING_STATUS) && !u_sync.fail_now ##1 !$rose(sync_forward_fail_flag)
      |-> !sync_forward_fail_flag || $past(sync_forward_fail_flag) == 1'b0)
    else $error("fail flag survived read");

  a_locked_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    sync_forward_mode_sel == FSI_MODE_OFF ##1 sync_forward_mode_sel == FSI_MODE_OFF
      |-> !sync_forward_locked) else $error("locked while off");

  sequence s_sync_good;
    sync_forward_mode_sel != FSI_MODE_OFF && fwd_sync_ok;
  endsequence

  a_lock_follows: assert property (@(posedge pclk) disable iff (!presetn)
    s_sync_good |=> sync_forward_locked) else $error("lock missing");

endmodule

// ==== tb/fsi_src_model.sv ====
// Far-side model: forwarding engine plus source event and status-read strobes
`timescale 1ns/1ps
module fsi_src_model
(
  // Clock
  input  wire logic pclk,
  // Toward the aggregator
  output logic [1:0] mode,
  output logic       frame_done,
  output logic       sync_ok,
  output logic [1:0] rx_ev,
  output logic [1:0] rx_rd,
  output logic       tx_ev,
  output logic       tx_rd
);
  initial
  begin
    {mode, frame_done, sync_ok, rx_ev, rx_rd, tx_ev, tx_rd} = '0;
  end

  // One-cycle strobes, packed {tx, rx1, rx0}
  task strobe(input logic [2:0] e, input logic [2:0] r);
    @(posedge pclk);
    {tx_ev, rx_ev} <= e;
    {tx_rd, rx_rd} <= r;
    @(posedge pclk);
    {tx_ev, rx_ev, tx_rd, rx_rd} <= '0;
  endtask

  // Mode and sync level, optional frame-sent pulse
  task engine(input logic [1:0] m, input logic ok, input logic fr);
    @(posedge pclk);
    mode <= m;
    sync_ok <= ok;
    frame_done <= fr;
    @(posedge pclk);
    frame_done <= 1'b0;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the forwarding status and interrupt aggregator
`timescale 1ns/1ps
module tb_top;
  import fsi_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic        irq, eirq, frame_done, sync_ok, tx_ev, tx_rd;
  logic [1:0]  mode, rx_ev, rx_rd;
  logic [7:0]  ctl;
  logic [2:0]  pend;
  int          fails, cmp_count, seed;

  initial
  begin
    pclk = 1'b0;
  end
  always #12.5 pclk = ~pclk;

  fsi_src_model u_fsi_src_model (.pclk(pclk), .mode(mode), .frame_done(frame_done),
    .sync_ok(sync_ok), .rx_ev(rx_ev), .rx_rd(rx_rd), .tx_ev(tx_ev), .tx_rd(tx_rd));

  fsi_irq_aggregator u_fsi_irq_aggregator (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_forward_mode_sel(mode),
    .fwd_frame_done(frame_done), .fwd_sync_ok(sync_ok), .rx_port_event(rx_ev),
    .rx_port_status_read(rx_rd), .tx_port_event(tx_ev),
    .tx_port_event_status_reg_read(tx_rd), .irq_to_controller(irq), .evt_irq(eirq));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Interrupt status expected from pending sources and control bits
  function logic [31:0] exp_sts(input logic [2:0] p, input logic [7:0] c);
    logic [7:0] s;
    s = {3'b000, p[2], 2'b00, p[1:0]};
    s[7] = |(s[4:0] & c[4:0]);
    return 32'(s);
  endfunction

  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    seed = 32'h0000_bab6;
    fails = 0;
    cmp_count = 0;
    {presetn, psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, FSI_ADDR_FORWARDING_STATUS + 4 * i, 0);
      chk(rd, 0);
    end
    apb(1'b0, 32'h0000_0040, 0);
    chk(32'(err), 1);
    chk(rd, 0);
    $display("test reset done");
    repeat (6)
    begin
      ctl = 8'($random(seed));
      apb(1'b1, FSI_ADDR_INT_CTL, 32'(ctl));
      apb(1'b0, FSI_ADDR_INT_CTL, 0);
      chk(rd, 32'(ctl & FSI_CTL_MASK));
    end
    $display("test control done");
    repeat (10)
    begin
      ctl = 8'($random(seed)) & FSI_CTL_MASK;
      pend = 3'($random(seed));
      apb(1'b1, FSI_ADDR_INT_CTL, 32'(ctl));
      u_fsi_src_model.strobe(pend, 3'b000);
      apb(1'b0, FSI_ADDR_INT_STS, 0);
      chk(rd, exp_sts(pend, ctl));
      chk(32'(irq), 32'(ctl[7]) & (exp_sts(pend, ctl) >> 7));
      // Only receive port 0 status read
      u_fsi_src_model.strobe(3'b000, 3'b001);
      apb(1'b0, FSI_ADDR_INT_STS, 0);
      chk(rd, exp_sts(pend & 3'b110, ctl));
      u_fsi_src_model.strobe(3'b000, 3'b110);
      apb(1'b0, FSI_ADDR_INT_STS, 0);
      chk(rd, 0);
      chk(32'(irq), 0);
    end
    $display("test pending done");
    for (int m = 0; m < 4; m++)
    begin
      u_fsi_src_model.engine(2'(m), 1'b1, 1'b0);
      apb(1'b0, FSI_ADDR_FORWARDING_STATUS, 0);
      chk(rd, 32'(m != 0));
    end
    // Sync lost before any frame went out
    u_fsi_src_model.engine(2'b01, 1'b0, 1'b0);
    apb(1'b0, FSI_ADDR_FORWARDING_STATUS, 0);
    chk(rd, 0);
    apb(1'b1, FSI_ADDR_EVT_EN, 32'h0000_0001);
    apb(1'b1, FSI_ADDR_EVT_CLR, 32'h0000_0007);
    u_fsi_src_model.engine(2'b01, 1'b1, 1'b1);
    u_fsi_src_model.engine(2'b01, 1'b0, 1'b0);
    apb(1'b0, FSI_ADDR_FORWARDING_STATUS, 0);
    chk(rd, 32'h0000_0004);
    @(negedge pclk);
    chk(32'(eirq), 1);
    apb(1'b0, FSI_ADDR_FORWARDING_STATUS, 0);
    chk(rd, 0);
    apb(1'b1, FSI_ADDR_EVT_CLR, 32'h0000_0007);
    apb(1'b0, FSI_ADDR_EVT_STS, 0);
    chk(rd, 0);
    chk(32'(eirq), 0);
    $display("test sync done");
    finish_test;
  end

  initial
  begin
    #(25 * 20000);
    fails++;
    finish_test;
  end
endmodule
